// ---- wl_lock_pkg.sv ----
// Package: opcodes, sizes and layout constants for the write-latch/lock interpreter
package wl_lock_pkg;
    localparam int OPC_W = 8;
    localparam int ADDR_W = 24;
    localparam int BLK_SHIFT = 12;                  // 4 kB lock granule
    localparam int BLK_W = ADDR_W - BLK_SHIFT;      // 12-bit block index
    localparam int NUM_BLK = 1 << BLK_W;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CMD_BITS = 6'h08;
    localparam logic [CNT_W-1:0] ADDR_CMD_BITS = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam logic [2:0] BYTE_MASK = 3'h7;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_VOL_EN = 8'h50;
    localparam logic [7:0] OP_BLK_LOCK = 8'h36;
    localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_WRSR_X = 8'h71;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_PP_DUAL = 8'ha2;
    localparam logic [7:0] OP_PP_QUAD = 8'h32;
    localparam logic [7:0] OP_SEQ_A = 8'haf;
    localparam logic [7:0] OP_SEQ_B = 8'had;
    localparam logic [7:0] OP_ER_4K = 8'h20;
    localparam logic [7:0] OP_ER_32K = 8'h52;
    localparam logic [7:0] OP_ER_64K = 8'hd8;
    localparam logic [7:0] OP_ER_CHIP_A = 8'h60;
    localparam logic [7:0] OP_ER_CHIP_B = 8'hc7;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam logic LOCK_RESET = 1'b1;
endpackage : wl_lock_pkg

// ---- wl_lock_cmd.sv ----
// Serial command interpreter for the write latch and per-block lock array
`timescale 1ns/1ps
`default_nettype none
module wl_lock_cmd
    import wl_lock_pkg::*;
(
    input wire logic ref_clk_i,                           // System clock, 50 MHz
    input wire logic sys_rst_i,                           // Async reset, high
    input wire logic spi_cs_n_i,                          // Chip select, low active
    input wire logic spi_sclk_i,                          // Serial clock pin
    input wire logic spi_si_i,                            // Serial data in pin
    input wire logic protect_scheme_select_i,             // Per-block scheme on
    input wire logic range_protect_i,                     // Range scheme verdict
    input wire logic [wl_lock_pkg::ADDR_W-1:0] query_addr_i, // Protection query
    output logic write_latch_bit_o,                       // Write latch state
    output logic vol_write_perm_o,                        // Volatile write permit
    output logic query_protected_o,                       // Query address protected: lock bit or range verdict
    output logic cmd_refused_o,                           // Gated command pulse
    output logic [wl_lock_pkg::OPC_W-1:0] cmd_opcode_o,   // Opcode of last permitted command pulse
    output logic cmd_go_o                                 // Permitted command pulse
);
    // Pin synchronisers, two stages before any logic
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] si_sync;
    logic cs_q;
    logic sclk_q;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            si_sync <= 2'h0;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
        end
        else
        begin
            cs_sync <= {cs_sync[0], spi_cs_n_i};
            sclk_sync <= {sclk_sync[0], spi_sclk_i};
            si_sync <= {si_sync[0], spi_si_i};
            cs_q <= cs_sync[1];
            sclk_q <= sclk_sync[1];
        end
    end

    logic cs_n;
    logic sclk_rise;
    logic cs_rise;
    assign cs_n = cs_sync[1];
    assign sclk_rise = sclk_sync[1] & ~sclk_q & ~cs_n;
    assign cs_rise = cs_n & ~cs_q;

    // Opcode gated by the write latch
    function automatic logic needs_latch(input logic [OPC_W-1:0] op);
        case (op)
            OP_PP, OP_PP_DUAL, OP_PP_QUAD, OP_SEQ_A, OP_SEQ_B,
            OP_ER_4K, OP_ER_32K, OP_ER_64K, OP_ER_CHIP_A, OP_ER_CHIP_B,
            OP_OTP_PROG, OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_WRSR_X,
            OP_BLK_LOCK, OP_BLK_UNLOCK: needs_latch = 1'b1;
            default: needs_latch = 1'b0;
        endcase
    endfunction

    function automatic logic is_sr_write(input logic [OPC_W-1:0] op);
        is_sr_write = (op == OP_WRSR1) || (op == OP_WRSR2) ||
                      (op == OP_WRSR3) || (op == OP_WRSR_X);
    endfunction

    // Shift state: opcode, address and bit count
    logic [OPC_W-1:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] bit_cnt;
    logic [OPC_W-1:0] next_opcode;
    logic [ADDR_W-1:0] next_addr;
    logic [CNT_W-1:0] next_bit_cnt;

    // Upper count sticks past the address, low bits keep the byte phase
    always_comb
    begin
        next_opcode = opcode;
        next_addr = addr;
        next_bit_cnt = bit_cnt;
        if (cs_n)
        begin
            next_opcode = '0;
            next_addr = '0;
            next_bit_cnt = '0;
        end
        else if (sclk_rise)
        begin
            if (bit_cnt < CMD_BITS)
                next_opcode = {opcode[OPC_W-2:0], si_sync[1]};
            else if (bit_cnt < ADDR_CMD_BITS)
                next_addr = {addr[ADDR_W-2:0], si_sync[1]};
            if (bit_cnt < ADDR_CMD_BITS)
                next_bit_cnt = bit_cnt + CNT_W'(1'b1);
            else
                next_bit_cnt = {bit_cnt[CNT_W-1:3], bit_cnt[2:0] + 3'h1};
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            opcode <= '0;
            addr <= '0;
            bit_cnt <= '0;
        end
        else
        begin
            opcode <= next_opcode;
            addr <= next_addr;
            bit_cnt <= next_bit_cnt;
        end
    end

    // Execution decision at chip select rise (counts read before clearing)
    logic on_byte;
    logic has_op;
    logic has_addr;
    logic exec_ok;
    assign on_byte = (bit_cnt[2:0] & BYTE_MASK) == 3'h0;
    assign has_op = bit_cnt >= CMD_BITS;
    assign has_addr = bit_cnt >= ADDR_CMD_BITS;
    assign exec_ok = cs_rise & on_byte & has_op;

    // Write latch, volatile permit and lock array
    logic write_latch_bit;
    logic vol_perm;
    logic next_wel;
    logic next_vol_perm;
    logic lock_we;
    logic lock_val;
    logic refused;
    logic go;
    logic [BLK_W-1:0] blk_idx;
    logic [NUM_BLK-1:0] lock_bits;

    assign blk_idx = addr[ADDR_W-1:BLK_SHIFT];

    always_comb
    begin
        next_wel = write_latch_bit;
        next_vol_perm = vol_perm;
        lock_we = 1'b0;
        lock_val = LOCK_RESET;
        refused = 1'b0;
        go = 1'b0;
        if (exec_ok)
        begin
            if (is_sr_write(opcode) && vol_perm)
            begin
                go = 1'b1;
                next_vol_perm = 1'b0;
            end
            else if (needs_latch(opcode) && !write_latch_bit)
            begin
                refused = 1'b1;
                if (is_sr_write(opcode))
                    next_vol_perm = 1'b0;
            end
            else
            begin
                next_vol_perm = 1'b0;
                case (opcode)
                    OP_WR_EN: next_wel = 1'b1;
                    OP_WR_DIS: next_wel = 1'b0;
                    OP_VOL_EN: next_vol_perm = 1'b1;
                    OP_BLK_LOCK, OP_BLK_UNLOCK:
                    begin
                        // Truncated address: no lock write, latch kept, volatile permit still cleared
                        if (has_addr)
                        begin
                            lock_we = 1'b1;
                            lock_val = (opcode == OP_BLK_LOCK);
                            next_wel = 1'b0;
                        end
                    end
                    default: go = needs_latch(opcode);
                endcase
            end
        end
    end

    // Lock array as flops: every bit must preset, which a RAM cannot do
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            lock_bits <= {NUM_BLK{LOCK_RESET}};
        else if (lock_we)
            lock_bits[blk_idx] <= lock_val;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            write_latch_bit <= 1'b0;
            vol_perm <= 1'b0;
            cmd_refused_o <= 1'b0;
            cmd_go_o <= 1'b0;
            cmd_opcode_o <= '0;
            query_protected_o <= LOCK_RESET;
        end
        else
        begin
            write_latch_bit <= next_wel;
            vol_perm <= next_vol_perm;
            cmd_refused_o <= refused;
            cmd_go_o <= go;
            if (go)
                cmd_opcode_o <= opcode;
            query_protected_o <= protect_scheme_select_i ?
                lock_bits[query_addr_i[ADDR_W-1:BLK_SHIFT]] : range_protect_i;
        end
    end

    assign write_latch_bit_o = write_latch_bit;
    assign vol_write_perm_o = vol_perm;

    // Assertions
    property p_wdis;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && opcode == OP_WR_DIS && !is_sr_write(opcode)) |=> !write_latch_bit;
    endproperty
    a_wdis: assert property (p_wdis) else $error("write disable kept latch");

    property p_gate;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && needs_latch(opcode) && !write_latch_bit && !(is_sr_write(opcode) && vol_perm))
        |=> cmd_refused_o && !cmd_go_o;
    endproperty
    a_gate: assert property (p_gate) else $error("gated command ran");

    property p_abort;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (cs_rise && !on_byte) |=> $stable(write_latch_bit) && $stable(lock_bits) && $stable(vol_perm);
    endproperty
    a_abort: assert property (p_abort) else $error("misaligned deselect acted");

    property p_vol_no_wel;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && opcode == OP_VOL_EN) |=> (write_latch_bit == $past(write_latch_bit)) && vol_perm;
    endproperty
    a_vol_no_wel: assert property (p_vol_no_wel) else $error("vol enable moved latch");

    property p_vol_once;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && vol_perm && is_sr_write(opcode)) |=> cmd_go_o && !vol_perm;
    endproperty
    a_vol_once: assert property (p_vol_once) else $error("vol permit not withdrawn");

    property p_lock;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && write_latch_bit && has_addr && opcode == OP_BLK_LOCK && !vol_perm)
        |=> lock_bits[$past(blk_idx)] && !write_latch_bit;
    endproperty
    a_lock: assert property (p_lock) else $error("block lock failed");

    property p_unlock;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && write_latch_bit && has_addr && opcode == OP_BLK_UNLOCK && !vol_perm)
        |=> !lock_bits[$past(blk_idx)] && !write_latch_bit;
    endproperty
    a_unlock: assert property (p_unlock) else $error("block unlock failed");

    property p_lock_needs_wel;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !write_latch_bit |=> $stable(lock_bits);
    endproperty
    a_lock_needs_wel: assert property (p_lock_needs_wel) else $error("lock without latch");

    property p_wen;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (exec_ok && opcode == OP_WR_EN) |=> write_latch_bit;
    endproperty
    a_wen: assert property (p_wen) else $error("write enable missed");

    property p_scheme;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && !protect_scheme_select_i) |=> query_protected_o == $past(range_protect_i);
    endproperty
    a_scheme: assert property (p_scheme) else $error("wrong protection source");

    property p_clear;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cs_n |=> bit_cnt == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");

    c_wen: cover property (@(posedge ref_clk_i) exec_ok && opcode == OP_WR_EN);
    c_lock: cover property (@(posedge ref_clk_i) lock_we && lock_val);
    c_unlock: cover property (@(posedge ref_clk_i) lock_we && !lock_val);
    c_abort: cover property (@(posedge ref_clk_i) cs_rise && !on_byte && has_op);
endmodule // wl_lock_cmd
`default_nettype wire

// ---- spi_host_model.sv ----
// Behavioural SPI host, mode 0, driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic ref_clk_i, // Bench clock, 50 MHz
    output logic spi_cs_n_o,    // Chip select, low active
    output logic spi_sclk_o,    // Serial clock, still low between frames
    output logic spi_si_o       // Serial data to device
);
    // Idle pins at time zero
    initial
    begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_si_o = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Shift n bits of w from bit 31 down; 4 ref cycles per half of 80 ns
    // MSB first
    // whole frame unless truncated on purpose
    task automatic frame(input logic [31:0] w, input int n);
        int i;
        wait_cyc(1);
        spi_cs_n_o <= 1'b0;
        wait_cyc(4);
        for (i = 0; i < n; i++)
        begin
            spi_si_o <= w[31-i];
            wait_cyc(4);
            spi_sclk_o <= 1'b1;
            wait_cyc(4);
            spi_sclk_o <= 1'b0;
        end
        wait_cyc(4);
        spi_cs_n_o <= 1'b1;
        // Deselected data line shows the inverse, never a stale value
        spi_si_o <= ~spi_si_o;
        wait_cyc(10);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- wl_lock_cmd_tb_top.sv ----
// Self-checking bench for the write latch and block lock interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module wl_lock_cmd_tb_top;
    import wl_lock_pkg::*;
    logic ref_clk, sys_rst, scheme, range_prot, wl, vp, qp, refused, go;
    logic [ADDR_W-1:0] qaddr;
    logic [OPC_W-1:0] opcode;
    wire logic cs_n, sclk, si;
    int miscompares = 0;
    int samples_checked = 0;
    int go_cnt = 0;
    int ref_cnt = 0;
    logic [7:0] gated [15] = '{8'h02, 8'ha2, 8'h32, 8'haf, 8'had, 8'h20, 8'h52, 8'hd8,
        8'h60, 8'hc7, 8'h9b, 8'h01, 8'h31, 8'h11, 8'h71};

    spi_host_model HOST (.ref_clk_i(ref_clk), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
        .spi_si_o(si));
    wl_lock_cmd DUT (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .spi_cs_n_i(cs_n),
        .spi_sclk_i(sclk), .spi_si_i(si), .protect_scheme_select_i(scheme),
        .range_protect_i(range_prot), .query_addr_i(qaddr), .write_latch_bit_o(wl),
        .vol_write_perm_o(vp), .query_protected_o(qp), .cmd_refused_o(refused),
        .cmd_opcode_o(opcode), .cmd_go_o(go));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Pulse counters; pulses stand one cycle so each edge is looked at
    always @(posedge ref_clk)
    begin
        if (go === 1'b1) go_cnt++;
        if (refused === 1'b1) ref_cnt++;
    end

    task automatic cmd(input logic [7:0] op);
        HOST.frame({op, 24'h0}, 8);
    endtask

    task automatic qchk(input logic [23:0] a, input logic ex);
        qaddr <= a;
        repeat (3) @(posedge ref_clk);
        `CHK("query_protected", ex, qp)
    endtask

    task automatic t_reset();
        scheme <= 1'b1;
        `CHK("permit", 1'b0, vp)
        qchk(24'h000000, 1'b1);
        qchk(24'hfff000, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_latch();
        cmd(OP_WR_EN);
        `CHK("latch", 1'b1, wl)
        cmd(OP_WR_DIS);
        `CHK("latch", 1'b0, wl)
        $display("test latch done");
    endtask

    // Truncated frames change nothing and raise no pulse
    task automatic t_abort();
        int g0 = go_cnt;
        int r0 = ref_cnt;
        cmd(OP_WR_EN);
        HOST.frame({OP_WR_DIS, 24'h0}, 7);
        `CHK("latch", 1'b1, wl)
        HOST.frame({OP_WR_DIS, 24'h0}, 12);
        `CHK("latch", 1'b1, wl)
        cmd(OP_WR_DIS);
        HOST.frame({OP_WR_EN, 24'h0}, 7);
        `CHK("latch", 1'b0, wl)
        HOST.frame({OP_PP, 24'h0}, 5);
        `CHK("pulses", {g0, r0}, {go_cnt, ref_cnt})
        $display("test abort done");
    endtask

    task automatic t_gate();
        int g0;
        int r0;
        foreach (gated[k])
        begin
            g0 = go_cnt;
            r0 = ref_cnt;
            cmd(gated[k]);
            `CHK("refused", {g0, r0 + 1}, {go_cnt, ref_cnt})
            cmd(OP_WR_EN);
            cmd(gated[k]);
            `CHK("go", g0 + 1, go_cnt)
            `CHK("opcode", gated[k], opcode)
            cmd(OP_WR_DIS);
        end
        $display("test gate done");
    endtask

    task automatic t_vol();
        int g0 = go_cnt;
        int r0;
        cmd(OP_VOL_EN);
        `CHK("latch", 1'b0, wl)
        `CHK("permit", 1'b1, vp)
        cmd(OP_WRSR1);
        `CHK("go", g0 + 1, go_cnt)
        `CHK("permit", 1'b0, vp)
        r0 = ref_cnt;
        cmd(OP_WRSR1);
        `CHK("refused", r0 + 1, ref_cnt)
        $display("test volatile done");
    endtask

    task automatic t_lock();
        int r0;
        cmd(OP_WR_EN);
        HOST.frame({OP_BLK_UNLOCK, 24'h001234}, 32);
        `CHK("latch", 1'b0, wl)
        qchk(24'h001000, 1'b0);
        qchk(24'h001fff, 1'b0);
        qchk(24'h002000, 1'b1);
        qchk(24'h000fff, 1'b1);
        r0 = ref_cnt;
        HOST.frame({OP_BLK_UNLOCK, 24'h005000}, 32);
        `CHK("refused", r0 + 1, ref_cnt)
        qchk(24'h005000, 1'b1);
        cmd(OP_WR_EN);
        HOST.frame({OP_BLK_UNLOCK, 24'h005000}, 24);
        `CHK("latch", 1'b1, wl)
        qchk(24'h005000, 1'b1);
        HOST.frame({OP_BLK_LOCK, 24'h001abc}, 32);
        `CHK("latch", 1'b0, wl)
        qchk(24'h001800, 1'b1);
        cmd(OP_WR_EN);
        HOST.frame({OP_BLK_UNLOCK, 24'hfffffe}, 32);
        qchk(24'hfff000, 1'b0);
        $display("test lock done");
    endtask

    // Scheme select off: range verdict wins over lock bits
    task automatic t_scheme();
        scheme <= 1'b0;
        range_prot <= 1'b1;
        qchk(24'hfff000, 1'b1);
        range_prot <= 1'b0;
        qchk(24'h002000, 1'b0);
        scheme <= 1'b1;
        qchk(24'h002000, 1'b1);
        $display("test scheme done");
    endtask

    // Mid-run reset must relock every block and drop the latch
    task automatic t_rereset();
        cmd(OP_WR_EN);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK("latch", 1'b0, wl)
        qchk(24'hfff000, 1'b1);
        $display("test reset again done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog: about eight times the expected run
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end

    initial
    begin
        sys_rst = 1'b1;
        scheme = 1'b0;
        range_prot = 1'b0;
        qaddr = '0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_latch();
        t_abort();
        t_gate();
        t_vol();
        t_lock();
        t_scheme();
        t_rereset();
        end_sim();
    end
endmodule // wl_lock_cmd_tb_top
`default_nettype wire
